/* File: rtl/sds_cfg.svh */
`ifndef SDS_CFG_SVH
`define SDS_CFG_SVH
// ---------------------------------------------------------------
// configuration bit positions (second bank)
// ---------------------------------------------------------------
`define SDS_CFG_STREAM_EN_BIT   7
`define SDS_CFG_TRANSPORT_BIT   5
// ---------------------------------------------------------------
// frame constants
// ---------------------------------------------------------------
`define SDS_SYNC_BYTE           8'haa
`define SDS_I2C_ADDR            7'h44
`define SDS_SHORT_BYTES         4'h5
`define SDS_LONG_BYTES          4'h8
// ---------------------------------------------------------------
// timing: clock period and durations in ns
// ---------------------------------------------------------------
`define SDS_CLK_NS              10
`define SDS_BIT_NS              10000
`define SDS_EVENT_NS            1600000
`define SDS_BIT_CYC             (`SDS_BIT_NS / `SDS_CLK_NS)
`define SDS_EVENT_CYC           (`SDS_EVENT_NS / `SDS_CLK_NS)
`endif

/* File: rtl/sds_pkg.sv */
package sds_pkg;
    // one measurement as handed over by the sensing core
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] long_term_average;
        logic        touch;
        logic        prox;
        logic [5:0]  mult;
        logic [7:0]  comp;
        logic [7:0]  counter;
        logic        act_high;
        logic        halt;
        logic        low_power;
        logic        noise;
        logic        zoom;
    } sds_meas_t;

    typedef enum logic [3:0] {
        SDS_IDLE  = 4'b0001,
        SDS_START = 4'b0010,
        SDS_DATA  = 4'b0100,
        SDS_STOP  = 4'b1000
    } sds_state_t;
endpackage : sds_pkg

/* File: rtl/sds_stream.sv */
`include "sds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - stream only when enable bit 7 set
// - bit 5 picks one-wire or I2C
// - one-wire on touch pin; I2C prox/touch
// - device sends frame after every charge, except one that finds both buffer entries full
// - frame opens with low start bit
// - sync byte 0xaa follows start bit
// - five or eight data bytes follow
// - every byte has start and stop
// - stop is high, no fixed length
// - fixed byte order of frame
// - byte 6 touch, prox, multiplier
// - event pulse low 1.6ms on prox pin
// - I2C target address 0x44
// - raw counts always IIR filtered
// - tuning at start-up and out of range
// - tuning busy flag, events suppressed
// - retune only on large sensitivity loss
// - multiplier and compensation reported in long frames only
module sds_stream
    import sds_pkg::*;
#(
    parameter int BIT_CYC   = `SDS_BIT_CYC,
    parameter int EVENT_CYC = `SDS_EVENT_CYC
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire logic [7:0] cfg_bank2,
    input  wire logic      short_mode,
    input  wire logic      event_mode,
    input  wire logic      charge_done,
    input  wire sds_meas_t meas,
    input  wire logic [15:0] raw_count,
    input  wire logic [15:0] range_lo,
    input  wire logic [15:0] range_hi,
    input  wire logic      tune_done,
    output logic           tout_o,
    output logic           tout_oe,
    output logic           pout_o,
    output logic           pout_oe,
    output logic           i2c_sel,
    output logic           tune_busy,
    output logic           touch_out,
    output logic           prox_out,
    output logic [15:0]    filt_count,
    output logic           frame_ready,
    output logic           busy
);
    // refuse timings the counters cannot serve: a zero length would never tick
    if (BIT_CYC < 1 || EVENT_CYC < 1) begin : g_bad_timing
        $error("bad timing parameters");
    end

    // ---------------------------------------------------------------
    // configuration decode
    // ---------------------------------------------------------------
    logic stream_en;
    logic use_i2c;
    assign stream_en = cfg_bank2[`SDS_CFG_STREAM_EN_BIT];
    assign use_i2c   = cfg_bank2[`SDS_CFG_TRANSPORT_BIT];

    // ---------------------------------------------------------------
    // raw filter and tuning
    // ---------------------------------------------------------------
    logic [15:0] filt_r, filt_nxt;
    logic        tune_r, tune_nxt, tch_r, tch_nxt, prx_r, prx_nxt;
    // filter has no bypass: noise must never reach detection
    always_comb begin
        filt_nxt = filt_r;
        tune_nxt = tune_r;
        tch_nxt  = tch_r;
        prx_nxt  = prx_r;
        if (charge_done) begin
            filt_nxt = filt_r - (filt_r >> 2) + (raw_count >> 2);
            // only a large shift retunes; small drift is tracked by filter
            if (filt_r < range_lo || filt_r > range_hi) tune_nxt = 1'b1;
        end
        if (tune_r && tune_done) tune_nxt = 1'b0;
        tch_nxt = tune_r ? 1'b0 : meas.touch;
        prx_nxt = tune_r ? 1'b0 : meas.prox;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_r <= 16'h0000;
            tune_r <= 1'b1; // tuning at start-up
            tch_r  <= 1'b0;
            prx_r  <= 1'b0;
        end else if (ce) begin
            filt_r <= filt_nxt;
            tune_r <= tune_nxt;
            tch_r  <= tch_nxt;
            prx_r  <= prx_nxt;
        end
    end

    // ---------------------------------------------------------------
    // frame assembly into two-entry buffer
    // ---------------------------------------------------------------
    logic [71:0] frame;
    // touch and proximity come from this cycle's masked values, not last cycle's
    always_comb begin
        frame = {`SDS_SYNC_BYTE,
                 meas.count[15:8], meas.count[7:0],
                 meas.long_term_average[15:8], meas.long_term_average[7:0],
                 1'b0, meas.act_high, meas.halt, meas.low_power,
                 tune_r, meas.noise, meas.zoom, 1'b0,
                 tch_nxt, prx_nxt, meas.mult,
                 meas.comp, meas.counter};
    end

    logic [71:0] buf_q [2];
    logic [1:0]  short_q; // frame length chosen at its own charge cycle
    logic [1:0]  cnt_r, cnt_nxt;
    logic        wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic        push, pop, buf_rdy, buf_vld;
    assign buf_rdy = (cnt_r != 2'd2);
    assign buf_vld = (cnt_r != 2'd0);
    // a charge cycle with a full buffer is dropped, never overwritten
    assign push = charge_done && stream_en && !use_i2c && buf_rdy;
    always_comb begin
        cnt_nxt    = cnt_r + {1'b0, push} - {1'b0, pop};
        wr_ptr_nxt = wr_ptr_r ^ push;
        rd_ptr_nxt = rd_ptr_r ^ pop;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r    <= 2'd0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
        end else if (ce) begin
            cnt_r    <= cnt_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
        end
    end
    // payload store has no reset: an entry is only read after it was written
    always_ff @(posedge clk) begin
        if (ce && push) begin
            buf_q[wr_ptr_r]   <= frame;
            short_q[wr_ptr_r] <= short_mode;
        end
    end

    // ---------------------------------------------------------------
    // one-wire serialiser
    // ---------------------------------------------------------------
    sds_state_t  st_r, st_nxt;
    logic [71:0] sh_r, sh_nxt;
    logic [3:0]  byte_r, byte_nxt, nbytes_r, nbytes_nxt;
    logic [2:0]  bit_r, bit_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    logic        line_nxt, line_r;
    logic        tick;
    // one bit lasts BIT_CYC cycles; the timer rests at zero while idle
    assign tick = (tmr_r == 32'(BIT_CYC - 1));
    assign pop  = (st_r == SDS_IDLE) && buf_vld && stream_en && !use_i2c;
    always_comb begin
        st_nxt     = st_r;
        sh_nxt     = sh_r;
        byte_nxt   = byte_r;
        nbytes_nxt = nbytes_r;
        bit_nxt    = bit_r;
        tmr_nxt    = (st_r == SDS_IDLE || tick) ? 32'd0 : tmr_r + 32'd1;
        line_nxt   = 1'b1;
        unique case (st_r)
            SDS_IDLE: begin
                if (pop) begin
                    sh_nxt     = buf_q[rd_ptr_r];
                    byte_nxt   = 4'd0;
                    nbytes_nxt = short_q[rd_ptr_r] ? `SDS_SHORT_BYTES : `SDS_LONG_BYTES;
                    st_nxt     = SDS_START;
                end
            end
            SDS_START: begin
                line_nxt = 1'b0; // start bit held low
                if (tick) begin
                    st_nxt  = SDS_DATA;
                    bit_nxt = 3'd0;
                end
            end
            SDS_DATA: begin
                line_nxt = sh_r[71]; // msb first
                if (tick) begin
                    sh_nxt  = {sh_r[70:0], 1'b0};
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) st_nxt = SDS_STOP;
                end
            end
            SDS_STOP: begin
                line_nxt = 1'b1; // stop bit: one period high here
                if (tick) begin
                    byte_nxt = byte_r + 4'd1;
                    st_nxt   = (byte_r == nbytes_r) ? SDS_IDLE : SDS_START;
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= SDS_IDLE;
            sh_r     <= 72'h0;
            byte_r   <= 4'h0;
            nbytes_r <= 4'h0;
            bit_r    <= 3'h0;
            tmr_r    <= 32'h0;
            line_r   <= 1'b1;
        end else if (ce) begin
            st_r     <= st_nxt;
            sh_r     <= sh_nxt;
            byte_r   <= byte_nxt;
            nbytes_r <= nbytes_nxt;
            bit_r    <= bit_nxt;
            tmr_r    <= tmr_nxt;
            line_r   <= line_nxt;
        end
    end

    // ---------------------------------------------------------------
    // event pulse on proximity pin
    // ---------------------------------------------------------------
    logic [31:0] ev_r, ev_nxt;
    logic        ev_low;
    always_comb begin
        ev_nxt = (ev_r != 32'd0) ? ev_r - 32'd1 : 32'd0;
        if (event_mode && stream_en && !use_i2c && (tch_nxt != tch_r || prx_nxt != prx_r))
            ev_nxt = 32'(EVENT_CYC);
    end
    assign ev_low = (ev_nxt != 32'd0);
    // a change during a pulse restarts the full low time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ev_r <= 32'd0;
        else if (ce) ev_r <= ev_nxt;
    end

    // ---------------------------------------------------------------
    // registered outputs; I2C engine lives outside, pins steered here
    // ---------------------------------------------------------------
    // outputs except frame_ready take next values so the pins line up with the state they show
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_o      <= 1'b1;
            tout_oe     <= 1'b0;
            pout_o      <= 1'b1;
            pout_oe     <= 1'b0;
            i2c_sel     <= 1'b0;
            tune_busy   <= 1'b1;
            touch_out   <= 1'b0;
            prox_out    <= 1'b0;
            filt_count  <= 16'h0;
            frame_ready <= 1'b0;
            busy        <= 1'b0;
        end else if (ce) begin
            tout_o      <= line_nxt;
            tout_oe     <= stream_en && !use_i2c;
            pout_o      <= !ev_low;
            pout_oe     <= stream_en && !use_i2c && event_mode;
            i2c_sel     <= stream_en && use_i2c;
            tune_busy   <= tune_nxt;
            touch_out   <= tch_nxt;
            prox_out    <= prx_nxt;
            filt_count  <= filt_nxt;
            frame_ready <= buf_vld;
            busy        <= (st_nxt != SDS_IDLE);
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // assertions watch registered pins where they can, so a broken
    // output stage cannot hide behind correct next-state logic
    a_stream_gated: assert property (@(posedge clk) disable iff (!rst_n)
        ce && !stream_en |=> !tout_oe && !i2c_sel) else $error("pins driven while disabled");
    a_start_low: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st_r == SDS_START |=> !tout_o) else $error("start bit not low");
    a_stop_high: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st_r == SDS_STOP |=> tout_o) else $error("stop bit not high");
    a_sync_first: assert property (@(posedge clk) disable iff (!rst_n)
        ce && pop |=> sh_r[71:64] == `SDS_SYNC_BYTE) else $error("sync byte wrong");
    a_byte_count: assert property (@(posedge clk) disable iff (!rst_n)
        ce && pop && short_q[rd_ptr_r] |=> nbytes_r == `SDS_SHORT_BYTES)
        else $error("short count");
    a_tune_mask: assert property (@(posedge clk) disable iff (!rst_n)
        ce && tune_r |=> !tch_r && !prx_r) else $error("event during tuning");
    a_flag_zero: assert property (@(posedge clk) disable iff (!rst_n)
        ce && st_r == SDS_DATA && byte_r == 4'd5 && (bit_r == 3'd0 || bit_r == 3'd7)
        |-> !sh_r[71]) else $error("flag pad bit set");
    a_i2c_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        ce && stream_en && use_i2c |=> i2c_sel && !tout_oe)
        else $error("one-wire pin driven in i2c mode");
    a_event_low: assert property (@(posedge clk) disable iff (!rst_n)
        ce && ev_low |=> !pout_o) else $error("event pulse not low");

    c_frame: cover property (@(posedge clk) pop);
    c_event: cover property (@(posedge clk) ev_r == 32'(EVENT_CYC));
    c_full: cover property (@(posedge clk) cnt_r == 2'd2);
    c_short: cover property (@(posedge clk) pop && short_q[rd_ptr_r]);
    c_tune_frame: cover property (@(posedge clk) push && tune_r);
endmodule : sds_stream
`default_nettype wire

/* File: verif/sds_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sds_host_model #(
    parameter int BIT_CYC = 4
) (
    input  wire logic       clk,
    input  wire logic       tout_line,
    input  wire logic       pout_line,
    output logic [7:0]      rx_byte,
    output logic            rx_stb,
    output logic            stop_bad,
    output int              ev_len
);
    logic       prev = 1'b1;
    logic [7:0] b;
    int         run = 0;
    always @(posedge clk) prev <= tout_line;
    // --------------------------------------------------------------
    // one-wire receiver
    // --------------------------------------------------------------
    // re-syncs on each falling start edge, never counts the stop length
    initial begin
        rx_stb = 1'b0;
        stop_bad = 1'b0;
        rx_byte = 8'h00;
        forever begin
            @(posedge clk);
            rx_stb <= 1'b0;
            if (prev && !tout_line) begin
                repeat (BIT_CYC + BIT_CYC / 2 - 1) @(posedge clk);
                for (int i = 7; i >= 0; i--) begin // bit timing fixed by BIT_CYC
                    b[i] = tout_line;
                    repeat (BIT_CYC) @(posedge clk);
                end
                rx_byte <= b;
                stop_bad <= !tout_line;
                rx_stb <= 1'b1;
            end
        end
    end
    // width of the last low notification on the event line
    always @(posedge clk) begin
        if (!pout_line) begin
            run <= run + 1;
        end else begin
            if (run != 0) ev_len <= run;
            run <= 0;
        end
    end
endmodule : sds_host_model
`default_nettype wire

/* File: verif/sds_stream_tb.sv */
`include "sds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sds_stream_tb
    import sds_pkg::*;
;
    localparam int BIT_CYC = 4;
    localparam int EVENT_CYC = 20;
    logic        clk = 1'b0;
    logic        rst_n, ce, short_mode, event_mode, charge_done, tune_done;
    logic [7:0]  cfg_bank2;
    sds_meas_t   meas;
    logic [15:0] raw_count, range_lo, range_hi, filt_count;
    logic        tout_o, tout_oe, pout_o, pout_oe, i2c_sel, tune_busy;
    logic        touch_out, prox_out, frame_ready, busy, rx_stb, stop_bad;
    logic [7:0]  rx_byte;
    logic [7:0]  exp_q[$];
    logic        exp_tune = 1'b0;
    int          ev_len;
    int          num_errors = 0;
    int          samples_checked = 0;
    integer      seed = 32'h00192953;
    sds_meas_t   m;
    wire         tout_line = tout_oe ? tout_o : 1'b1; // pull-up when released
    wire         pout_line = pout_oe ? pout_o : 1'b1;
    always #5 clk = ~clk;
    sds_stream #(.BIT_CYC(BIT_CYC), .EVENT_CYC(EVENT_CYC)) DUT (
        .clk(clk), .rst_n(rst_n), .ce(ce), .cfg_bank2(cfg_bank2), .short_mode(short_mode),
        .event_mode(event_mode), .charge_done(charge_done), .meas(meas),
        .raw_count(raw_count), .range_lo(range_lo), .range_hi(range_hi),
        .tune_done(tune_done), .tout_o(tout_o), .tout_oe(tout_oe), .pout_o(pout_o),
        .pout_oe(pout_oe), .i2c_sel(i2c_sel), .tune_busy(tune_busy),
        .touch_out(touch_out), .prox_out(prox_out), .filt_count(filt_count),
        .frame_ready(frame_ready), .busy(busy));
    sds_host_model #(.BIT_CYC(BIT_CYC)) host (
        .clk(clk), .tout_line(tout_line), .pout_line(pout_line), .rx_byte(rx_byte),
        .rx_stb(rx_stb), .stop_bad(stop_bad), .ev_len(ev_len));
    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    function automatic sds_meas_t rnd_meas();
        logic [63:0] r;
        r = {$random(seed), $random(seed)};
        return r[60:0];
    endfunction : rnd_meas
    // expected bytes of one frame; exp_tune sets the busy flag and masks events
    task automatic push_frame(input sds_meas_t v, input logic s);
        logic [7:0] f [9];
        f = '{`SDS_SYNC_BYTE, v.count[15:8], v.count[7:0], v.long_term_average[15:8], v.long_term_average[7:0],
              {1'b0, v.act_high, v.halt, v.low_power, exp_tune, v.noise, v.zoom, 1'b0},
              {v.touch & ~exp_tune, v.prox & ~exp_tune, v.mult}, v.comp, v.counter};
        for (int i = 0; i < (s ? 6 : 9); i++) exp_q.push_back(f[i]);
    endtask : push_frame
    // leaves charge_done high so two calls in a row give back-to-back requests
    task automatic charge(input sds_meas_t v, input logic s, input logic sends);
        @(posedge clk);
        meas <= v;
        short_mode <= s;
        charge_done <= 1'b1;
        if (sends) push_frame(v, s);
    endtask : charge
    task automatic wait_idle();
        @(posedge clk);
        charge_done <= 1'b0;
        repeat (4) @(posedge clk);
        for (int n = 0; n < 3000 && (busy !== 1'b0 || frame_ready !== 1'b0); n++)
            @(posedge clk);
        repeat (2 * BIT_CYC) @(posedge clk);
        check(16'(busy), 16'h0000);
    endtask : wait_idle
    task automatic pulse_tune();
        @(posedge clk);
        tune_done <= 1'b1;
        @(posedge clk);
        tune_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse_tune
    task automatic give_verdict();
        check(16'(exp_q.size()), 16'h0000);
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    // every received byte against the expected queue
    always @(posedge clk) begin
        if (rx_stb) begin
            if (exp_q.size() == 0) check(16'h0001, 16'h0000);
            else check({8'h00, rx_byte}, {8'h00, exp_q.pop_front()});
            check(16'(stop_bad), 16'h0000);
        end
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_n, short_mode, event_mode, charge_done, tune_done} = 5'h00;
        ce = 1'b1;
        cfg_bank2 = 8'h00;
        meas = '0;
        raw_count = 16'h0100;
        range_lo = 16'h0000;
        range_hi = 16'hffff;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 check(16'(tune_busy), 16'h0001);
        pulse_tune();
        check(16'(tune_busy), 16'h0000);
        @(posedge clk) cfg_bank2 <= 8'h80;
        charge('1, 1'b0, 1'b1);
        wait_idle();
        check(16'({touch_out, prox_out, tout_oe}), 16'h0007);
        for (int k = 0; k < 6; k++) begin
            charge(rnd_meas(), k[0], 1'b1);
            wait_idle();
        end
        charge(rnd_meas(), 1'b0, 1'b1);
        charge(rnd_meas(), 1'b1, 1'b1);
        charge(rnd_meas(), 1'b0, 1'b1);
        @(posedge clk) charge_done <= 1'b0;
        repeat (2) @(posedge clk);
        check(16'(frame_ready), 16'h0001);
        wait_idle();
        check(16'(frame_ready), 16'h0000);
        check(16'(i2c_sel), 16'h0000);
        check(16'(ev_len), 16'h0000);
        @(posedge clk) event_mode <= 1'b1;
        m = rnd_meas();
        m.touch = ~touch_out;
        charge(m, 1'b0, 1'b1);
        wait_idle();
        check(16'(ev_len), 16'(EVENT_CYC));
        check(16'(pout_oe), 16'h0001);
        @(posedge clk) {event_mode, cfg_bank2} <= {1'b0, 8'h00};
        charge(rnd_meas(), 1'b0, 1'b0);
        wait_idle();
        check(16'(tout_oe), 16'h0000);
        @(posedge clk) cfg_bank2 <= 8'ha0;
        charge(rnd_meas(), 1'b0, 1'b0);
        wait_idle();
        check(16'(i2c_sel), 16'h0001);
        @(posedge clk) {cfg_bank2, raw_count, range_hi} <= {8'h00, 16'hffff, 16'h8000};
        for (int k = 0; k < 40; k++) begin
            charge(rnd_meas(), 1'b0, 1'b0);
            wait_idle();
        end
        check(16'(filt_count >= 16'hfff0), 16'h0001);
        check(16'(tune_busy), 16'h0001);
        @(posedge clk) cfg_bank2 <= 8'h80;
        exp_tune = 1'b1;
        m = rnd_meas();
        {m.touch, m.prox} = 2'b11;
        charge(m, 1'b1, 1'b1);
        wait_idle();
        check(16'({touch_out, prox_out}), 16'h0000);
        give_verdict();
    end
    // watchdog, well past the expected run length
    initial begin
        #500000;
        num_errors++;
        give_verdict();
    end
endmodule : sds_stream_tb
`default_nettype wire
